//--- hdl/intc_pkg.sv
// Constants for the two-level interrupt controller.
// Assumes a 32-bit APB slave with byte addresses in an 8-bit window.
`default_nettype none

package intc_pkg;

  // ==========================================================
  // Register offsets
  localparam int             ADDR_W    = 8;
  localparam logic [7:0]     OFS_ICM   = 8'h00;
  localparam logic [7:0]     OFS_RCR   = 8'h04;
  localparam logic [7:0]     OFS_PFLG  = 8'h08;
  localparam logic [7:0]     OFS_PEN   = 8'h0c;
  localparam logic [7:0]     OFS_PPRI  = 8'h10;
  localparam logic [7:0]     OFS_CPRI  = 8'h14;
  localparam logic [7:0]     OFS_ISTS  = 8'h18;
  localparam logic [7:0]     OFS_IMSK  = 8'h1c;
  localparam logic [7:0]     OFS_STAT  = 8'h20;

  // ==========================================================
  // Field positions of interrupt_control_main
  localparam int             GEN_HI_B  = 7;
  localparam int             GEN_LO_B  = 6;
  localparam int             EN_LO     = 3;
  localparam int             FL_LO     = 0;
  localparam int             TFL_B     = 2;
  localparam int             XFL_B     = 1;
  localparam int             CFL_B     = 0;
  localparam int             XEN_B     = 4;
  localparam int             PRIO_B    = 0;

  // ==========================================================
  // Reset values and vectors
  localparam logic [7:0]     ICM_RST   = 8'h00;
  localparam logic [7:0]     RCR_RST   = 8'h00;
  localparam logic [7:0]     PER_RST   = 8'h00;
  localparam logic [2:0]     CPRI_RST  = 3'h0;
  localparam int             VEC_W     = 16;
  localparam logic [15:0]    VEC_HIGH  = 16'h0008;
  localparam logic [15:0]    VEC_LOW   = 16'h0018;

  // ==========================================================
  // Event status bits
  localparam int             EV_W      = 3;
  localparam int             EV_HI     = 0;
  localparam int             EV_LO     = 1;
  localparam int             EV_RET    = 2;

  // ==========================================================
  // Handler state
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_LOW  = 2'b01,
    ST_NEST = 2'b11,
    ST_HIGH = 2'b10
  } hstate_t;

endpackage : intc_pkg

`default_nettype wire

//--- hdl/sync2.sv
// Two-flop synchroniser for asynchronous pin levels.
// Assumes the destination runs on pclk.
`default_nettype none

module sync2 #(
  parameter int W = 1
) (
  input  wire logic         pclk,
  input  wire logic         presetn,
  input  wire logic         ce,
  input  wire logic [W-1:0] d,
  output var  logic [W-1:0] q
);

  logic [W-1:0] meta_reg;

  // ==========================================================
  // Two stages
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_reg <= '0;
      q        <= '0;
    end else if (ce) begin
      meta_reg <= d;
      q        <= meta_reg;
    end
  end

endmodule : sync2

`default_nettype wire

//--- hdl/irq_sticky.sv
// Sticky event status, mask and one level interrupt output.
// Assumes event pulses and clear strobes on pclk.
`default_nettype none

module irq_sticky #(
  parameter int W = 3
) (
  input  wire logic         pclk,
  input  wire logic         presetn,
  input  wire logic         ce,
  input  wire logic [W-1:0] evt,
  input  wire logic         clr_we,
  input  wire logic [W-1:0] clr_data,
  input  wire logic         mask_we,
  input  wire logic [W-1:0] mask_data,
  output var  logic [W-1:0] status,
  output var  logic [W-1:0] mask,
  output var  logic         irq
);

  // ==========================================================
  // Status, set wins over write-one-clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      status <= '0;
    end else if (ce) begin
      status <= (status & ~(clr_we ? clr_data : '0)) | evt;
    end
  end

  // ==========================================================
  // Mask and output
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mask <= '0;
      irq  <= 1'b0;
    end else if (ce) begin
      if (mask_we) begin
        mask <= mask_data;
      end
      irq <= |(status & mask);
    end
  end

endmodule : irq_sticky

`default_nettype wire

//--- hdl/intc_top.sv
// Two-level interrupt controller with APB registers and core vectoring.
// Assumes core handshake and events on pclk; pins are asynchronous.
// Operation
// - Every source has a flag, an enable and a priority bit.
// - Priority enable clear by default; priority bits then ignored.
// - Compatibility: peripheral enable gates peripherals only, with global set.
// - Compatibility: global enable allows core sources, clear blocks everything.
// - Compatibility: every accepted interrupt vectors to 0008h.
// - Priority enable set selects two levels; enables become high and low.
// - High enable set allows high sources; clear blocks all sources.
// - Low enable clear blocks low sources; set allows them with high set.
// - Flag, enable and level enable set vector to 0008h or 0018h.
// - Acceptance clears the matching global or level enable.
// - High preempts a low handler; low waits during a high handler.
// - Core pushes return address and loads the offered vector.
// - Return op sets back the enable cleared on entry.
// - Pin and port-change events reach the vector in three to four cycles.
// - Flags set on events whatever the enable bits.
// - Main register: enables 7 and 6, then source enables and flags.
//
// The APB register port and the register addresses are this design's own decisions.
`default_nettype none

module intc_top #(
  parameter int PER_W  = 8,
  parameter int PORT_W = 4
) (
  input  wire logic                      pclk,
  input  wire logic                      presetn,
  input  wire logic                      ce,
  input  wire logic                      psel,
  input  wire logic                      penable,
  input  wire logic                      pwrite,
  input  wire logic [intc_pkg::ADDR_W-1:0] paddr,
  input  wire logic [31:0]               pwdata,
  output var  logic [31:0]               prdata,
  output var  logic                      pready,
  output var  logic                      pslverr,
  input  wire logic                      timer_evt,
  input  wire logic                      ext_pin,
  input  wire logic [PORT_W-1:0]         gp_port_b,
  input  wire logic [PER_W-1:0]          periph_evt,
  input  wire logic                      vec_ack,
  input  wire logic                      return_from_handler_op,
  output var  logic                      irq_req,
  output var  logic                      vec_high,
  output var  logic [intc_pkg::VEC_W-1:0] vec_addr,
  output var  logic                      irq
);
  import intc_pkg::*;

  logic [7:0]        icm_reg;
  logic [7:0]        icm_next;
  logic [7:0]        rcr_reg;
  logic [PER_W-1:0]  pflg_reg;
  logic [PER_W-1:0]  pen_reg;
  logic [PER_W-1:0]  ppri_reg;
  logic [2:0]        cpri_reg;
  hstate_t           st_reg;
  hstate_t           st_next;
  logic              ack_reg;
  logic              wr_en;
  logic              taken;
  logic [PORT_W:0]   pin_s;
  logic [PORT_W-1:0] port_d_reg;
  logic              ext_d_reg;
  logic              ext_rise;
  logic              port_chg;
  logic              prio_on;
  logic [2:0]        core_pend;
  logic [PER_W-1:0]  per_pend;
  logic              high_any;
  logic              low_any;
  logic              hi_ok;
  logic              lo_ok;
  logic [EV_W-1:0]   ev;
  logic [EV_W-1:0]   ists;
  logic [EV_W-1:0]   imsk;
  logic [31:0]       rd_val;
  logic              rd_err;

  // ==========================================================
  // Pin synchronisers and event detect
  sync2 #(.W(PORT_W + 1)) u_sync (
    .pclk    (pclk),
    .presetn (presetn),
    .ce      (ce),
    .d       ({gp_port_b, ext_pin}),
    .q       (pin_s)
  );

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ext_d_reg  <= 1'b0;
      port_d_reg <= '0;
    end else if (ce) begin
      ext_d_reg  <= pin_s[0];
      port_d_reg <= pin_s[PORT_W:1];
    end
  end

  assign ext_rise = pin_s[0] & ~ext_d_reg;
  assign port_chg = |(pin_s[PORT_W:1] ^ port_d_reg);

  // ==========================================================
  // APB slave, one wait state
  assign wr_en  = ce & psel & penable & pwrite & ack_reg;
  assign pready = ack_reg;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ack_reg <= 1'b0;
      prdata  <= '0;
      pslverr <= 1'b0;
    end else if (ce) begin
      ack_reg <= psel & penable & ~ack_reg;
      if (psel && penable && !ack_reg) begin
        prdata  <= pwrite ? 32'h0000_0000 : rd_val;
        pslverr <= rd_err;
      end
    end
  end

  always_comb begin
    rd_val = '0;
    rd_err = 1'b0;
    case (paddr)
      OFS_ICM:  rd_val[7:0]       = icm_reg;
      OFS_RCR:  rd_val[7:0]       = rcr_reg;
      OFS_PFLG: rd_val[PER_W-1:0] = pflg_reg;
      OFS_PEN:  rd_val[PER_W-1:0] = pen_reg;
      OFS_PPRI: rd_val[PER_W-1:0] = ppri_reg;
      OFS_CPRI: rd_val[2:0]       = cpri_reg;
      OFS_ISTS: rd_val[EV_W-1:0]  = ists;
      OFS_IMSK: rd_val[EV_W-1:0]  = imsk;
      OFS_STAT: rd_val[2:0]       = {irq_req, st_reg};
      default:  rd_err            = 1'b1;
    endcase
  end

  // ==========================================================
  // Mode and peripheral registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rcr_reg  <= RCR_RST;
      pen_reg  <= PER_RST[PER_W-1:0];
      ppri_reg <= PER_RST[PER_W-1:0];
      cpri_reg <= CPRI_RST;
    end else if (ce && wr_en) begin
      if (paddr == OFS_RCR) rcr_reg <= pwdata[7:0];
      if (paddr == OFS_PEN) pen_reg <= pwdata[PER_W-1:0];
      if (paddr == OFS_PPRI) ppri_reg <= pwdata[PER_W-1:0];
      if (paddr == OFS_CPRI) cpri_reg <= pwdata[2:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pflg_reg <= PER_RST[PER_W-1:0];
    end else if (ce) begin
      pflg_reg <= ((wr_en && paddr == OFS_PFLG) ?
                   pwdata[PER_W-1:0] : pflg_reg) | periph_evt;
    end
  end

  // ==========================================================
  // Main control register
  assign taken = vec_ack & irq_req;

  always_comb begin
    icm_next = icm_reg;
    if (wr_en && paddr == OFS_ICM) begin
      icm_next = pwdata[7:0];
    end
    // core source flags, event beats clear
    icm_next[TFL_B] = icm_next[TFL_B] | timer_evt;
    icm_next[XFL_B] = icm_next[XFL_B] | ext_rise;
    icm_next[CFL_B] = icm_next[CFL_B] | port_chg;
    if (return_from_handler_op) begin
      if (st_reg == ST_LOW) icm_next[GEN_LO_B] = 1'b1;
      else icm_next[GEN_HI_B] = 1'b1;
    end
    if (taken) begin
      if (prio_on && !vec_high) icm_next[GEN_LO_B] = 1'b0;
      else icm_next[GEN_HI_B] = 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      icm_reg <= ICM_RST;
    end else if (ce) begin
      icm_reg <= icm_next;
    end
  end

  // ==========================================================
  // Eligibility
  // priority bits only count in two-level mode
  assign prio_on   = rcr_reg[PRIO_B];
  assign core_pend = icm_reg[EN_LO+2:EN_LO] & icm_reg[FL_LO+2:FL_LO];
  assign per_pend  = pflg_reg & pen_reg;
  assign high_any  = |(core_pend & cpri_reg) | |(per_pend & ppri_reg);
  assign low_any   = |(core_pend & ~cpri_reg) | |(per_pend & ~ppri_reg);

  always_comb begin
    if (prio_on) begin
      hi_ok = icm_reg[GEN_HI_B] & high_any;
      lo_ok = icm_reg[GEN_HI_B] & icm_reg[GEN_LO_B] & low_any;
    end else begin
      hi_ok = icm_reg[GEN_HI_B] &
              (|core_pend | (icm_reg[GEN_LO_B] & |per_pend));
      lo_ok = 1'b0;
    end
  end

  // ==========================================================
  // Vector request to core
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_req  <= 1'b0;
      vec_high <= 1'b0;
      vec_addr <= VEC_HIGH;
    end else if (ce) begin
      irq_req  <= (hi_ok | lo_ok) & ~taken;
      vec_high <= hi_ok;
      vec_addr <= hi_ok ? VEC_HIGH : VEC_LOW;
    end
  end

  // ==========================================================
  // Handler nesting
  always_comb begin
    st_next = st_reg;
    case (st_reg)
      ST_IDLE: begin
        if (taken) st_next = vec_high ? ST_HIGH : ST_LOW;
      end
      ST_LOW: begin
        if (taken && vec_high) st_next = ST_NEST;
        else if (return_from_handler_op) st_next = ST_IDLE;
      end
      ST_NEST: begin
        if (return_from_handler_op) st_next = ST_LOW;
      end
      ST_HIGH: begin
        if (return_from_handler_op) st_next = ST_IDLE;
      end
      default: st_next = ST_IDLE;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_reg <= ST_IDLE;
    end else if (ce) begin
      st_reg <= st_next;
    end
  end

  // ==========================================================
  // Event interrupt
  assign ev[EV_HI]  = taken & vec_high;
  assign ev[EV_LO]  = taken & ~vec_high;
  assign ev[EV_RET] = return_from_handler_op;

  irq_sticky #(.W(EV_W)) u_irq (
    .pclk      (pclk),
    .presetn   (presetn),
    .ce        (ce),
    .evt       (ev),
    .clr_we    (wr_en && paddr == OFS_ISTS),
    .clr_data  (pwdata[EV_W-1:0]),
    .mask_we   (wr_en && paddr == OFS_IMSK),
    .mask_data (pwdata[EV_W-1:0]),
    .status    (ists),
    .mask      (imsk),
    .irq       (irq)
  );

  // ==========================================================
  // Checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_compat_vec_addr: assert property (
    ce && irq_req && !prio_on && !$past(prio_on)
      |-> vec_high && vec_addr == 16'h0008)
    else $error("compat request not at high vector");

  a_vec_by_level: assert property (
    irq_req |-> vec_addr == (vec_high ? 16'h0008 : 16'h0018))
    else $error("vector address does not match level");

  a_ack_clears_main: assert property (
    ce && taken && (vec_high || !prio_on) && !return_from_handler_op
      |=> !icm_reg[7])
    else $error("enable not cleared on high accept");

  a_ack_clears_low: assert property (
    ce && taken && !vec_high && prio_on && !return_from_handler_op
      |=> !icm_reg[6] && st_reg == ST_LOW)
    else $error("low enable not cleared on accept");

  a_ret_restores: assert property (
    ce && return_from_handler_op && !taken
      |=> (($past(st_reg) == ST_LOW) ? icm_reg[6] : icm_reg[7]))
    else $error("return did not restore enable");

  a_flag_sets: assert property (
    ce && timer_evt |=> icm_reg[2])
    else $error("timer flag not set");
  a_pin_latency: assert property (
    (ce && ext_rise && icm_reg[7] && icm_reg[4]
      && (!prio_on || cpri_reg[XFL_B])
      && !taken && !return_from_handler_op && !wr_en)
      ##1 (ce && !wr_en) |-> ##1 irq_req)
    else $error("pin event did not reach request in time");

  a_global_blocks: assert property (
    !icm_reg[7] |=> !irq_req)
    else $error("request while global enable clear");
  a_periph_gate: assert property (
    !prio_on && !icm_reg[6] && core_pend == 3'h0 |=> !irq_req)
    else $error("peripheral request passed clear gate");

  a_nest_entry: assert property (
    ce && taken && vec_high && st_reg == ST_LOW
      |=> st_reg == ST_NEST ##0 !icm_reg[7])
    else $error("preemption did not nest");

  a_high_first: assert property (
    ce && hi_ok && lo_ok && !taken |=> irq_req && vec_high)
    else $error("low served before high");

  c_compat_take: cover property (taken && !prio_on);
  c_low_take:    cover property (taken && !vec_high);
  c_nest:        cover property (st_reg == ST_NEST);
  c_irq_out:     cover property (irq);

endmodule : intc_top

`default_nettype wire

//--- tb/core_model.sv
// Behavioural core: takes offered vectors, issues return pulses.
// Assumes request, acknowledge and return all run on pclk.
`default_nettype none

module core_model
  import intc_pkg::*;
(
  input  wire logic             pclk,
  input  wire logic             presetn,
  input  wire logic [3:0]       ack_dly,
  input  wire logic             ret_cmd,
  input  wire logic             irq_req,
  input  wire logic [VEC_W-1:0] vec_addr,
  output var  logic             vec_ack,
  output var  logic             return_from_handler_op,
  output var  logic [VEC_W-1:0] pc
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [3:0] wait_cnt;
  logic [3:0] depth;

  // ==========================================================
  // Acceptance
  // push and vector load
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      vec_ack  <= 1'b0;
      wait_cnt <= 4'h0;
      pc       <= 16'h0000;
    end else if (vec_ack) begin
      vec_ack  <= 1'b0;
      wait_cnt <= 4'h0;
      if (irq_req) begin
        pc <= vec_addr;
      end
    end else if (irq_req && wait_cnt >= ack_dly) begin
      vec_ack <= 1'b1;
    end else if (irq_req) begin
      wait_cnt <= wait_cnt + 4'h1;
    end else begin
      wait_cnt <= 4'h0;
    end
  end

  // ==========================================================
  // Return and stack depth
  // hardware stack
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      return_from_handler_op <= 1'b0;
      depth                  <= 4'h0;
    end else begin
      return_from_handler_op <= ret_cmd;
      depth <= depth + {3'h0, vec_ack & irq_req}
                     - {3'h0, return_from_handler_op};
    end
  end
endmodule : core_model

`default_nettype wire

//--- tb/two_level_interrupt_controller_bench.sv
// Self-checking bench for the two-level interrupt controller.
// Assumes core_model stands in for the core; ce is held high.
`default_nettype none

module two_level_interrupt_controller_bench
  import intc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic        timer_evt, ext_pin, ret_cmd, vec_ack, rfh, irq_req;
  logic        vec_high, irq;
  logic        ce = 1'b1;
  logic [7:0]  paddr, periph_evt;
  logic [31:0] pwdata, prdata;
  logic [3:0]  gp_port_b, ack_dly;
  logic [15:0] vec_addr;
  logic [16:0] vq[$];
  logic [32:0] rq[$];
  int          mismatches, cmp_count;
  integer      seed;
  logic [7:0]  m;

  intc_top u_intc_top (.pclk(pclk), .presetn(presetn), .ce(ce),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .timer_evt(timer_evt), .ext_pin(ext_pin),
    .gp_port_b(gp_port_b), .periph_evt(periph_evt), .vec_ack(vec_ack),
    .return_from_handler_op(rfh), .irq_req(irq_req),
    .vec_high(vec_high), .vec_addr(vec_addr), .irq(irq));

  core_model u_core_model (.pclk(pclk), .presetn(presetn),
    .ack_dly(ack_dly), .ret_cmd(ret_cmd), .irq_req(irq_req),
    .vec_addr(vec_addr), .vec_ack(vec_ack),
    .return_from_handler_op(rfh), .pc());

  // ==========================================================
  // Compare and report
  task automatic note(input string s, input logic [32:0] e, g);
    cmp_count++;
    if (g !== e) begin
      mismatches++;
      $display("unexpected %s expected %h seen %h", s, e, g);
    end
  endtask : note
  task automatic cmp_rd(input logic [32:0] e, g);
    note("read", e, g);
  endtask : cmp_rd
  task automatic cmp_vec(input logic [16:0] e, g);
    note("vector", {16'h0, e}, {16'h0, g});
  endtask : cmp_vec
  task automatic cmp_bit(input string s, input logic e, g);
    note(s, {32'h0, e}, {32'h0, g});
  endtask : cmp_bit
  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : end_of_test
  task automatic hang();
    mismatches++;
    end_of_test();
  endtask : hang

  // ==========================================================
  // Result watcher
  always @(posedge pclk) begin
    if (psel && penable && pready === 1'b1 && !pwrite && rq.size() > 0)
      cmp_rd(rq.pop_front(), {pslverr, prdata});
    if (vec_ack && irq_req === 1'b1)
      cmp_vec(vq.size() > 0 ? vq.pop_front() : 17'h0,
              {vec_high, vec_addr});
  end

  // ==========================================================
  // Drivers
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    psel    <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1) hang();
  endtask : apb
  task automatic wr(input logic [7:0] a, d);
    apb(1'b1, a, {24'h0, d});
  endtask : wr
  task automatic rd(input logic [7:0] a, e);
    rq.push_back({25'h0, e});
    apb(1'b0, a, 32'h0);
  endtask : rd
  task automatic pushv(input logic [15:0] v);
    vq.push_back({v == VEC_HIGH, v});
  endtask : pushv
  task automatic wait_taken();
    int n;
    for (n = 0; n < 40 && vq.size() > 0; n++) @(posedge pclk);
    if (vq.size() > 0) hang();
  endtask : wait_taken
  task automatic quiet();
    repeat (6) @(posedge pclk) cmp_bit("irq_req", 1'b0, irq_req);
  endtask : quiet
  task automatic pulse_per(input logic [7:0] v);
    @(posedge pclk) periph_evt <= v;
    @(posedge pclk) periph_evt <= 8'h00;
  endtask : pulse_per
  task automatic do_return();
    @(posedge pclk) ret_cmd <= 1'b1;
    @(posedge pclk) ret_cmd <= 1'b0;
    repeat (2) @(posedge pclk);
  endtask : do_return
  task automatic lat_check(input logic [3:0] pv);
    int n;
    pushv(VEC_HIGH);
    @(posedge pclk);
    ext_pin   <= 1'b1;
    gp_port_b <= pv;
    n = 0;
    do begin
      @(posedge pclk);
      #1;
      n++;
    end while (irq_req !== 1'b1 && n < 8);
    cmp_bit("latency", 1'b1, n >= 3 && n <= 4);
    wait_taken();
  endtask : lat_check

  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  // ==========================================================
  // Main sequence
  initial begin
    {presetn, psel, penable, pwrite, timer_evt, ext_pin, ret_cmd} = '0;
    {paddr, periph_evt, pwdata, gp_port_b, ack_dly} = '0;
    seed = 32'h13f0ccff;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    rd(OFS_ICM, 8'h00);
    rd(OFS_RCR, 8'h00);
    rq.push_back({1'b1, 32'h0});
    apb(1'b0, 8'h24, 32'h0);
    @(posedge pclk) timer_evt <= 1'b1;
    @(posedge pclk) timer_evt <= 1'b0;
    rd(OFS_ICM, 8'h04);
    wr(OFS_ICM, 8'ha0);
    pushv(VEC_HIGH);
    pulse_per(8'h00);
    @(posedge pclk) timer_evt <= 1'b1;
    @(posedge pclk) timer_evt <= 1'b0;
    wait_taken();
    rd(OFS_ICM, 8'h24);
    wr(OFS_ICM, 8'h20);
    do_return();
    rd(OFS_ICM, 8'ha0);
    wr(OFS_PEN, 8'h01);
    wr(OFS_ICM, 8'h40);
    pulse_per(8'h01);
    quiet();
    rd(OFS_PFLG, 8'h01);
    wr(OFS_ICM, 8'h80);
    quiet();
    pushv(VEC_HIGH);
    wr(OFS_ICM, 8'hc0);
    wait_taken();
    rd(OFS_ICM, 8'h40);
    wr(OFS_PFLG, 8'h00);
    do_return();
    rd(OFS_ICM, 8'hc0);
    wr(OFS_RCR, 8'h01);
    wr(OFS_PPRI, 8'h01);
    wr(OFS_PEN, 8'h03);
    ack_dly <= 4'($random(seed) & 3);
    pushv(VEC_HIGH);
    pulse_per(8'h03);
    wait_taken();
    quiet();
    rd(OFS_ICM, 8'h40);
    wr(OFS_PFLG, 8'h02);
    pushv(VEC_LOW);
    do_return();
    wait_taken();
    rd(OFS_ICM, 8'h80);
    rd(OFS_STAT, 8'h01);
    pushv(VEC_HIGH);
    pulse_per(8'h01);
    wait_taken();
    rd(OFS_STAT, 8'h03);
    rd(OFS_ICM, 8'h00);
    wr(OFS_PFLG, 8'h00);
    do_return();
    rd(OFS_ICM, 8'h80);
    do_return();
    rd(OFS_ICM, 8'hc0);
    wr(OFS_ICM, 8'h40);
    pulse_per(8'h03);
    quiet();
    wr(OFS_PFLG, 8'h00);
    wr(OFS_ICM, 8'h80);
    pulse_per(8'h02);
    quiet();
    pushv(VEC_HIGH);
    pulse_per(8'h01);
    wait_taken();
    wr(OFS_PFLG, 8'h00);
    do_return();
    rd(OFS_ISTS, 8'h07);
    cmp_bit("irq", 1'b0, irq);
    wr(OFS_IMSK, 8'h07);
    repeat (2) @(posedge pclk);
    cmp_bit("irq", 1'b1, irq);
    wr(OFS_ISTS, 8'h07);
    repeat (2) @(posedge pclk);
    cmp_bit("irq", 1'b0, irq);
    m = 8'($random(seed) & 7);
    wr(OFS_IMSK, m);
    rd(OFS_IMSK, m);
    wr(OFS_CPRI, 8'h03);
    wr(OFS_ICM, 8'h90);
    lat_check(4'h0);
    wr(OFS_ICM, 8'h10);
    do_return();
    rd(OFS_ICM, 8'h90);
    wr(OFS_ICM, 8'h88);
    lat_check(4'($random(seed) | 1));
    rd(OFS_ICM, 8'h09);
    end_of_test();
  end
endmodule : two_level_interrupt_controller_bench

`default_nettype wire
